// ===== src/acc_chan2_regs.sv
// Channel two configuration and calibration register bank, APB slave.
// Assumes same-clock sample source and global highpass setting.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
module acc_chan2_regs #(
  parameter int SAMPLE_W = 24
) (
  // Clock, reset, enable
  input  wire logic                       I_MCLK,
  input  wire logic                       I_RST,
  input  wire logic                       I_CE,
  // APB slave
  input  wire logic                       I_PSEL,
  input  wire logic                       I_PENABLE,
  input  wire logic                       I_PWRITE,
  input  wire logic [acc_pkg::APB_AW-1:0] I_PADDR,
  input  wire logic [acc_pkg::APB_DW-1:0] I_PWDATA,
  input  wire logic [3:0]                 I_PSTRB,
  output logic      [acc_pkg::APB_DW-1:0] O_PRDATA,
  output logic                            O_PREADY,
  output logic                            O_PSLVERR,
  // Channel controls
  input  wire logic                       I_GLOBAL_HIGHPASS_SETTING,
  output logic      [9:0]                 O_CHAN_TWO_DELAY_CYCLES,
  output logic                            O_HIGHPASS_ENABLE,
  output logic      [3:0]                 O_INPUT_ROUTE,
  // Conversion stream
  input  wire logic [SAMPLE_W-1:0]        I_SAMPLE_DATA,
  input  wire logic                       I_SAMPLE_VALID,
  output logic      [SAMPLE_W-1:0]        O_RESULT_DATA,
  output logic                            O_RESULT_VALID
);
  import acc_pkg::*;

  // The datapath is fixed at the documented conversion width
  if (SAMPLE_W != CAL_W) begin : g_width_check
    $error("SAMPLE_W must equal 24");
  end

  // The decode takes the index from bits 9:2 and wants bits above them
  if (APB_AW < 11) begin : g_addr_check
    $error("APB_AW must be at least 11");
  end

  // The configuration fields must end at the top of the register
  if (CFG_DELAY_LSB + CFG_DELAY_W != REG_W) begin : g_field_check
    $error("delay field must end at the top of the register");
  end

  // Configuration fields; reserved bits are never stored
  logic [CFG_DELAY_W-1:0] delay_reg,    delay_next;
  logic                   bypass_reg,   bypass_next;
  logic [CFG_SEL_W-1:0]   sel_reg,      sel_next;
  // Written halves, as software sees them
  logic [15:0]            ofs_hi_reg,   ofs_hi_next;
  logic [7:0]             ofs_lo_reg,   ofs_lo_next;
  logic [15:0]            gain_hi_reg,  gain_hi_next;
  logic [7:0]             gain_lo_reg,  gain_lo_next;
  // Committed values and pending-half flags
  logic [23:0]            ofs_act_reg,  ofs_act_next;
  logic [23:0]            gain_act_reg, gain_act_next;
  logic [1:0]             ofs_pend_reg, ofs_pend_next;
  logic [1:0]             gain_pend_reg, gain_pend_next;
  // Derived channel outputs
  logic                   hp_en_reg,    hp_en_next;
  logic [3:0]             route_reg,    route_next;
  // Bus answer
  logic [APB_DW-1:0]      rdata_reg,    rdata_next;
  logic                   err_reg,      err_next;
  // Set once read data and error are captured for the current transfer
  logic                   cap_reg,      cap_next;

  logic       setup;
  logic       wr_take;
  logic [7:0] idx;
  logic       aligned;
  logic       hit;

  acc_cal_if cal ();

  // Merge write data into a 16-bit register under the byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  strb);
    logic [15:0] m;
    m = old;
    if (strb[0]) begin
      m[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      m[15:8] = wd[15:8];
    end
    return m;
  endfunction

  // Is the index one of the mapped registers
  function automatic logic mapped(input logic [7:0] ix);
    return (ix == IDX_CFG) || (ix == IDX_OFS_HI) || (ix == IDX_OFS_LO)
        || (ix == IDX_GAIN_HI) || (ix == IDX_GAIN_LO)
        || (ix == IDX_STATUS);
  endfunction

  // Software image of the configuration register; reserved bits are zero
  function automatic logic [15:0] cfg_word(
      input logic [CFG_DELAY_W-1:0] dly,
      input logic                   byp,
      input logic [CFG_SEL_W-1:0]   sel);
    return {dly, 3'h0, byp, sel};
  endfunction

  // Software image of a low register; its lower byte is reserved
  function automatic logic [15:0] lo_word(input logic [7:0] fld);
    return {fld, 8'h00};
  endfunction

  // A pair commits once both of its halves carry a fresh write
  function automatic logic both_halves(input logic [1:0] pend);
    return pend == 2'h3;
  endfunction

  // Address decode; the upper address bits must be zero
  assign idx     = I_PADDR[9:2];
  assign aligned = (I_PADDR[1:0] == 2'h0)
                && (I_PADDR[APB_AW-1:10] == '0);
  assign hit     = aligned && mapped(idx);
  // Capture once per transfer: normally in the setup cycle, but if the
  // enable was low then, in the first access cycle that runs instead
  assign setup   = I_PSEL && !cap_reg;
  // A write lands only at the completing access edge
  assign wr_take = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && hit;

  // Register file next state
  always_comb begin
    logic [15:0] cfg_w;
    logic [15:0] lo_w;
    cfg_w = merge16(cfg_word(delay_reg, bypass_reg, sel_reg),
                    I_PWDATA[15:0], I_PSTRB[1:0]);
    lo_w  = merge16(16'h0000, I_PWDATA[15:0], I_PSTRB[1:0]);
    delay_next   = delay_reg;
    bypass_next  = bypass_reg;
    sel_next     = sel_reg;
    ofs_hi_next  = ofs_hi_reg;
    ofs_lo_next  = ofs_lo_reg;
    gain_hi_next = gain_hi_reg;
    gain_lo_next = gain_lo_reg;
    ofs_pend_next  = ofs_pend_reg;
    gain_pend_next = gain_pend_reg;
    if (wr_take) begin
      case (idx)
        IDX_CFG: begin
          delay_next  = cfg_w[CFG_DELAY_LSB +: CFG_DELAY_W];
          bypass_next = cfg_w[CFG_BYPASS_BIT];
          sel_next    = cfg_w[CFG_SEL_LSB +: CFG_SEL_W];
          // Bits 5:3 are simply dropped
        end
        IDX_OFS_HI: begin
          ofs_hi_next = merge16(ofs_hi_reg, I_PWDATA[15:0],
                                I_PSTRB[1:0]);
          ofs_pend_next[1] = 1'b1;
        end
        IDX_OFS_LO: begin
          if (I_PSTRB[1]) begin
            ofs_lo_next = lo_w[LO_FIELD_LSB +: 8];
          end
          ofs_pend_next[0] = 1'b1;
        end
        IDX_GAIN_HI: begin
          gain_hi_next = merge16(gain_hi_reg, I_PWDATA[15:0],
                                 I_PSTRB[1:0]);
          gain_pend_next[1] = 1'b1;
        end
        IDX_GAIN_LO: begin
          if (I_PSTRB[1]) begin
            gain_lo_next = lo_w[LO_FIELD_LSB +: 8];
          end
          gain_pend_next[0] = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // Commit a pair once both halves have landed, in either order; a lone
  // half leaves the datapath on the old pair, never on a mixture
  always_comb begin
    ofs_act_next  = ofs_act_reg;
    gain_act_next = gain_act_reg;
    if (both_halves(ofs_pend_next)) begin
      ofs_act_next = {ofs_hi_next, ofs_lo_next};
    end
    if (both_halves(gain_pend_next)) begin
      gain_act_next = {gain_hi_next, gain_lo_next};
    end
  end

  // Channel controls follow the stored fields
  always_comb begin
    hp_en_next = bypass_reg ? 1'b0 : I_GLOBAL_HIGHPASS_SETTING;
    case (sel_reg)
      SEL_PINS:  route_next = 4'h1;
      SEL_SHORT: route_next = 4'h2;
      SEL_POS:   route_next = 4'h4;
      SEL_NEG:   route_next = 4'h8;
      default:   route_next = 4'h1;
    endcase
  end

  // Read data and error are captured once per transfer, before the
  // access phase completes, so the answer comes from flip-flops
  always_comb begin
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (setup) begin
      err_next   = !hit;
      rdata_next = '0;
      case (idx)
        IDX_CFG:     rdata_next[15:0] = cfg_word(delay_reg, bypass_reg,
                                                 sel_reg);
        IDX_OFS_HI:  rdata_next[15:0] = ofs_hi_reg;
        IDX_OFS_LO:  rdata_next[15:0] = lo_word(ofs_lo_reg);
        IDX_GAIN_HI: rdata_next[15:0] = gain_hi_reg;
        IDX_GAIN_LO: rdata_next[15:0] = lo_word(gain_lo_reg);
        IDX_STATUS:  rdata_next[3:0]  = {gain_pend_reg, ofs_pend_reg};
        default:     rdata_next = '0;
      endcase
      if (!hit) begin
        rdata_next = '0;
      end
    end
  end

  // Capture flag: set by the capture, cleared as the transfer completes,
  // so a setup cycle spent frozen cannot leave stale data for the access
  always_comb begin
    cap_next = cap_reg;
    if (O_PREADY) begin
      cap_next = 1'b0;
    end else if (setup) begin
      cap_next = 1'b1;
    end
  end

  // All state registers; the enable freezes everything
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      delay_reg     <= RST_CFG[CFG_DELAY_LSB +: CFG_DELAY_W];
      bypass_reg    <= RST_CFG[CFG_BYPASS_BIT];
      sel_reg       <= RST_CFG[CFG_SEL_LSB +: CFG_SEL_W];
      ofs_hi_reg    <= RST_OFS_HI;
      ofs_lo_reg    <= RST_OFS_LO[LO_FIELD_LSB +: 8];
      gain_hi_reg   <= RST_GAIN_HI;
      gain_lo_reg   <= RST_GAIN_LO[LO_FIELD_LSB +: 8];
      ofs_act_reg   <= {RST_OFS_HI, RST_OFS_LO[LO_FIELD_LSB +: 8]};
      gain_act_reg  <= {RST_GAIN_HI, RST_GAIN_LO[LO_FIELD_LSB +: 8]};
      ofs_pend_reg  <= 2'h0;
      gain_pend_reg <= 2'h0;
      hp_en_reg     <= 1'b0;
      route_reg     <= 4'h1;
      rdata_reg     <= '0;
      err_reg       <= 1'b0;
      cap_reg       <= 1'b0;
    end else if (I_CE) begin
      delay_reg     <= delay_next;
      bypass_reg    <= bypass_next;
      sel_reg       <= sel_next;
      ofs_hi_reg    <= ofs_hi_next;
      ofs_lo_reg    <= ofs_lo_next;
      gain_hi_reg   <= gain_hi_next;
      gain_lo_reg   <= gain_lo_next;
      ofs_act_reg   <= ofs_act_next;
      gain_act_reg  <= gain_act_next;
      // Pending flags clear on commit; a fresh half reopens them
      ofs_pend_reg  <= both_halves(ofs_pend_next) ? 2'h0 : ofs_pend_next;
      gain_pend_reg <= both_halves(gain_pend_next) ? 2'h0 : gain_pend_next;
      hp_en_reg     <= hp_en_next;
      route_reg     <= route_next;
      rdata_reg     <= rdata_next;
      err_reg       <= err_next;
      cap_reg       <= cap_next;
    end
  end

  // Calibration link to the datapath
  assign cal.offset       = ofs_act_reg;
  assign cal.gain         = gain_act_reg;
  assign cal.sample       = I_SAMPLE_DATA[CAL_W-1:0];
  assign cal.sample_valid = I_SAMPLE_VALID;

  acc_cal_dp u_dp (
    .i_clk (I_MCLK),
    .i_rst (I_RST),
    .i_ce  (I_CE),
    .cal   (cal.dp)
  );

  // Zero wait states once the answer is captured; a frozen block holds
  // the master off, and a transfer whose setup was frozen waits a cycle
  assign O_PREADY  = I_PSEL && I_PENABLE && I_CE && cap_reg;
  assign O_PRDATA  = rdata_reg;
  assign O_PSLVERR = err_reg && O_PREADY;

  assign O_CHAN_TWO_DELAY_CYCLES = delay_reg;
  assign O_HIGHPASS_ENABLE       = hp_en_reg;
  assign O_INPUT_ROUTE           = route_reg;
  assign O_RESULT_DATA           = cal.result;
  assign O_RESULT_VALID          = cal.result_valid;
endmodule

// ===== src/acc_pkg.sv
// Constants for the channel two configuration and calibration block.
// Assumes an APB master with 32-bit data and one word per register.
// Operation
// - Delay field, bits 15:6, is a signed count of modulator cycles.
// - Configuration bits 5:3 ignore writes and read as zero.
// - Bypass 0 follows the global highpass setting; 1 bypasses this channel.
// - Select 00 pins, 01 shorted, 10 positive test, 11 negative test.
// - Configuration register resets to all zeros.
// - Offset high register gives offset bits 23:8.
// - Offset low register upper byte gives offset bits 7:0.
// - Assembled 24-bit offset is signed two's complement.
// - Offset low register lower byte ignores writes and reads zero.
// - Both offset registers reset to zero.
// - Gain high register gives gain bits 23:8.
// - Gain is unsigned, zero to just under two, step two over 2^24.
// - Gain high register resets to 8000h, giving unity gain.
// - Gain low upper byte gives gain bits 7:0; lower byte reads zero.
package acc_pkg;
  // Bus shape
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam int REG_W  = 16;
  localparam int CAL_W  = 24;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CFG     = 8'h13;
  localparam logic [7:0] IDX_OFS_HI  = 8'h14;
  localparam logic [7:0] IDX_OFS_LO  = 8'h15;
  localparam logic [7:0] IDX_GAIN_HI = 8'h16;
  localparam logic [7:0] IDX_GAIN_LO = 8'h17;
  localparam logic [7:0] IDX_STATUS  = 8'h3F;

  // Configuration field positions
  localparam int CFG_DELAY_LSB  = 6;
  localparam int CFG_DELAY_W    = 10;
  localparam int CFG_BYPASS_BIT = 2;
  localparam int CFG_SEL_LSB    = 0;
  localparam int CFG_SEL_W      = 2;
  localparam int LO_FIELD_LSB   = 8;

  // Reset values
  localparam logic [15:0] RST_CFG     = 16'h0000;
  localparam logic [15:0] RST_OFS_HI  = 16'h0000;
  localparam logic [15:0] RST_OFS_LO  = 16'h0000;
  localparam logic [15:0] RST_GAIN_HI = 16'h8000;
  localparam logic [15:0] RST_GAIN_LO = 16'h0000;

  // Input select codes
  localparam logic [1:0] SEL_PINS  = 2'h0;
  localparam logic [1:0] SEL_SHORT = 2'h1;
  localparam logic [1:0] SEL_POS   = 2'h2;
  localparam logic [1:0] SEL_NEG   = 2'h3;

  // Gain scaling: 800000h is unity, so the product shifts right by this
  localparam int GAIN_SHIFT = 23;
  localparam logic [23:0] SAT_MAX = 24'h7FFFFF;
  localparam logic [23:0] SAT_MIN = 24'h800000;
endpackage

// ===== src/acc_cal_if.sv
// Calibration link between the register bank and its datapath.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface acc_cal_if;
  logic [23:0] offset;
  logic [23:0] gain;
  logic [23:0] sample;
  logic        sample_valid;
  logic [23:0] result;
  logic        result_valid;

  // Register bank side
  modport ctrl (output offset, output gain, output sample,
                output sample_valid, input result, input result_valid);
  // Datapath side
  modport dp (input offset, input gain, input sample,
              input sample_valid, output result, output result_valid);
endinterface

// ===== src/acc_cal_dp.sv
// Offset and gain correction for one 24-bit conversion stream.
// Assumes offset and gain are stable committed values from the bank.
`timescale 1ns/10ps
module acc_cal_dp (
  // Clock and control
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  // Calibration link
  acc_cal_if.dp     cal
);
  import acc_pkg::*;

  logic signed [24:0] diff;
  logic signed [49:0] prod;
  logic        [26:0] scaled;
  logic        [23:0] res_reg;
  logic        [23:0] res_next;
  logic               vld_reg;
  logic               vld_next;

  // Correction arithmetic; one register stage keeps the path short
  always_comb begin
    diff = $signed({cal.sample[23], cal.sample})
         - $signed({cal.offset[23], cal.offset});
    prod = diff * $signed({1'b0, cal.gain});
    scaled = prod[GAIN_SHIFT +: 27];
    res_next = res_reg;
    vld_next = cal.sample_valid;
    if (cal.sample_valid) begin
      // Saturate when the top bits disagree with the sign
      if (scaled[26] == 1'b0 && scaled[25:23] != 3'h0) begin
        res_next = SAT_MAX;
      end else if (scaled[26] == 1'b1 && scaled[25:23] != 3'h7) begin
        res_next = SAT_MIN;
      end else begin
        res_next = scaled[23:0];
      end
    end
  end

  // Result registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      res_reg <= 24'h000000;
      vld_reg <= 1'b0;
    end else if (i_ce) begin
      res_reg <= res_next;
      vld_reg <= vld_next;
    end
  end

  assign cal.result       = res_reg;
  assign cal.result_valid = vld_reg;
endmodule

// ===== bench/acc_chan2_props.sv
// Port-level checks for the channel two register bank.
// Assumes it is bound to the bank top and sees only its ports.
`timescale 1ns/10ps
module acc_chan2_props #(
  parameter int SAMPLE_W = 24
) (
  input wire logic                       I_MCLK,
  input wire logic                       I_RST,
  input wire logic                       I_CE,
  input wire logic                       I_PSEL,
  input wire logic                       I_PENABLE,
  input wire logic                       I_PWRITE,
  input wire logic [acc_pkg::APB_AW-1:0] I_PADDR,
  input wire logic [acc_pkg::APB_DW-1:0] I_PWDATA,
  input wire logic [3:0]                 I_PSTRB,
  input wire logic [acc_pkg::APB_DW-1:0] O_PRDATA,
  input wire logic                       O_PREADY,
  input wire logic                       O_PSLVERR,
  input wire logic                       I_GLOBAL_HIGHPASS_SETTING,
  input wire logic [9:0]                 O_CHAN_TWO_DELAY_CYCLES,
  input wire logic                       O_HIGHPASS_ENABLE,
  input wire logic [3:0]                 O_INPUT_ROUTE,
  input wire logic [SAMPLE_W-1:0]        I_SAMPLE_DATA,
  input wire logic                       I_SAMPLE_VALID,
  input wire logic [SAMPLE_W-1:0]        O_RESULT_DATA,
  input wire logic                       O_RESULT_VALID
);
  import acc_pkg::*;
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  logic wr_done;
  logic cfg_wr;
  logic rd_ok;
  // Only full-strobe configuration writes give exact field values
  assign wr_done = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
  assign cfg_wr  = wr_done && I_PADDR == 12'h04C && I_PSTRB[1:0] == 2'h3;
  assign rd_ok   = O_PREADY && !I_PWRITE && !O_PSLVERR;

  property p_delay_load;
    cfg_wr |=> O_CHAN_TWO_DELAY_CYCLES == $past(I_PWDATA[15:6]);
  endproperty
  a_delay_load: assert property (p_delay_load)
    else $error("delay output misses written field");
  property p_delay_hold;
    !wr_done |=> $stable(O_CHAN_TWO_DELAY_CYCLES);
  endproperty
  a_delay_hold: assert property (p_delay_hold)
    else $error("delay output moved without a write");
  property p_cfg_resv;
    rd_ok && I_PADDR == 12'h04C |-> O_PRDATA[5:3] == 3'h0;
  endproperty
  a_cfg_resv: assert property (p_cfg_resv)
    else $error("reserved configuration bits read nonzero");
  property p_hp_follow;
    O_HIGHPASS_ENABLE && $past(I_CE) |-> $past(I_GLOBAL_HIGHPASS_SETTING);
  endproperty
  a_hp_follow: assert property (p_hp_follow)
    else $error("highpass enabled while global setting low");
  // The select lands at the write edge and the route one edge later
  property p_route;
    cfg_wr |-> ##2 O_INPUT_ROUTE == (4'h1 << $past(I_PWDATA[1:0], 2));
  endproperty
  a_route: assert property (p_route)
    else $error("input route does not match select code");
  property p_reset_out;
    $fell(I_RST) |-> O_CHAN_TWO_DELAY_CYCLES == 10'h000
      && O_INPUT_ROUTE == 4'h1 && !O_RESULT_VALID;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not at reset values after reset");
  property p_ofs_resv;
    rd_ok && I_PADDR == 12'h054 |-> O_PRDATA[7:0] == 8'h00;
  endproperty
  a_ofs_resv: assert property (p_ofs_resv)
    else $error("offset low reserved byte read nonzero");
  property p_gain_resv;
    rd_ok && I_PADDR == 12'h05C |-> O_PRDATA[7:0] == 8'h00;
  endproperty
  a_gain_resv: assert property (p_gain_resv)
    else $error("gain low reserved byte read nonzero");
  property p_result;
    I_SAMPLE_VALID && I_CE |=> O_RESULT_VALID;
  endproperty
  a_result: assert property (p_result)
    else $error("no result one cycle after a sample");
  property p_result_hold;
    I_CE && !I_SAMPLE_VALID |=> !O_RESULT_VALID && $stable(O_RESULT_DATA);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed without a sample");
  // A frozen block holds its bus answer off and its result unchanged
  property p_frozen;
    !I_CE |-> !O_PREADY ##1 ($stable(O_RESULT_DATA) && $stable(O_RESULT_VALID));
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("block moved while the enable was low");
  c_cfg_wr: cover property (cfg_wr);
  c_result: cover property (O_RESULT_VALID);
  c_err: cover property (O_PSLVERR);
  c_frozen: cover property (!I_CE && I_PSEL);
endmodule

// ===== bench/acc_chan2_regs_tb.sv
// Self-checking bench for the channel two register bank.
// Assumes a 10 MHz clock; the bench drives every port itself.
`timescale 1ns/10ps
module acc_chan2_regs_tb;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        glob = 1'b0;
  logic [23:0] sdata = 24'h0;
  logic        svld = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  strb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hp_en;
  logic        rvld;
  logic [9:0]  delay;
  logic [3:0]  route;
  logic [23:0] rdata;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;

  always #50 mclk = ~mclk;

  acc_chan2_regs #(.SAMPLE_W(24)) dut (
    .I_MCLK(mclk), .I_RST(rst), .I_CE(ce), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .I_PSTRB(strb), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_GLOBAL_HIGHPASS_SETTING(glob),
    .O_CHAN_TWO_DELAY_CYCLES(delay), .O_HIGHPASS_ENABLE(hp_en),
    .O_INPUT_ROUTE(route), .I_SAMPLE_DATA(sdata), .I_SAMPLE_VALID(svld),
    .O_RESULT_DATA(rdata), .O_RESULT_VALID(rvld));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [15:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge mclk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= {16'h0000, d};
    @(posedge mclk);
    pen <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0, "write error flag");
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic e_exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 16'h0000, r, e);
    chk(r, exp, "read data");
    chk({31'h0, e}, {31'h0, e_exp}, "read error flag");
  endtask

  // Registered outputs lag the write edge; wait past them, off the edge
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic samp(input logic [23:0] x, input logic [23:0] exp);
    @(posedge mclk);
    svld  <= 1'b1;
    sdata <= x;
    @(posedge mclk);
    svld <= 1'b0;
    #1;
    chk({7'h0, rvld, rdata}, {8'h01, exp}, "corrected result");
  endtask

  task automatic t_reset();
    rd(12'h04C, 32'h0, 1'b0);
    rd(12'h050, 32'h0, 1'b0);
    rd(12'h054, 32'h0, 1'b0);
    rd(12'h058, 32'h8000, 1'b0);
    rd(12'h05C, 32'h0, 1'b0);
    chk({28'h0, route}, 32'h1, "reset route");
    $display("test reset values done");
  endtask

  task automatic t_cfg();
    wr(12'h04C, 16'hFFFF);
    rd(12'h04C, 32'hFFC7, 1'b0);
    chk({22'h0, delay}, 32'h3FF, "delay all ones");
    for (int s = 0; s < 4; s++) begin
      wr(12'h04C, {10'h200, 4'h0, s[1:0]});
      settle();
      chk({28'h0, route}, 32'h1 << s, "route code");
      chk({22'h0, delay}, 32'h200, "delay most negative");
    end
    @(posedge mclk);
    glob <= 1'b1;
    wr(12'h04C, 16'h0004);
    settle();
    chk({31'h0, hp_en}, 32'h0, "bypassed");
    wr(12'h04C, 16'h0000);
    settle();
    chk({31'h0, hp_en}, 32'h1, "follows global high");
    @(posedge mclk);
    glob <= 1'b0;
    settle();
    chk({31'h0, hp_en}, 32'h0, "follows global low");
    $display("test configuration done");
  endtask

  task automatic t_dp();
    samp(24'h000200, 24'h000200);
    wr(12'h050, 16'h0001);
    samp(24'h000200, 24'h000200);
    wr(12'h054, 16'h0000);
    samp(24'h000200, 24'h000100);
    wr(12'h050, 16'hFFFF);
    wr(12'h054, 16'hFF00);
    samp(24'h7FFFFF, 24'h7FFFFF);
    samp(24'h800000, 24'h800001);
    wr(12'h058, 16'h4000);
    samp(24'h000201, 24'h000202);
    wr(12'h05C, 16'h0000);
    samp(24'h000201, 24'h000101);
    samp(24'hFFFFFC, 24'hFFFFFE);
    wr(12'h058, 16'hFFFF);
    wr(12'h05C, 16'hFF00);
    samp(24'h400000, 24'h7FFFFF);
    $display("test datapath done");
  endtask

  task automatic t_reg();
    wr(12'h050, 16'h1234);
    rd(12'h050, 32'h1234, 1'b0);
    rd(12'h0FC, 32'h2, 1'b0);
    wr(12'h054, 16'hFFFF);
    rd(12'h054, 32'hFF00, 1'b0);
    rd(12'h0FC, 32'h0, 1'b0);
    wr(12'h058, 16'hABCD);
    rd(12'h058, 32'hABCD, 1'b0);
    strb <= 4'h1;
    wr(12'h058, 16'h1111);
    strb <= 4'hF;
    rd(12'h058, 32'hAB11, 1'b0);
    wr(12'h05C, 16'h5A5A);
    rd(12'h05C, 32'h5A00, 1'b0);
    rd(12'h000, 32'h0, 1'b1);
    $display("test readback done");
  endtask

  // A low enable freezes the bank: the read waits, then completes with
  // data captured once the enable is back, not with the last answer
  task automatic t_ce();
    logic [31:0] r;
    logic        e;
    @(posedge mclk);
    ce <= 1'b0;
    fork
      apb(1'b0, 12'h058, 16'h0000, r, e);
      begin
        repeat (4) @(posedge mclk);
        chk({31'h0, pready}, 32'h0, "ready while frozen");
        ce <= 1'b1;
      end
    join
    chk(r, 32'hAB11, "read after freeze");
    chk({31'h0, e}, 32'h0, "error after freeze");
    $display("test clock enable done");
  endtask

  // Cut a hang short well above the fewer than two hundred cycles the tests need
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_cfg();
    t_dp();
    t_reg();
    t_ce();
    tally_and_finish();
  end
endmodule

bind acc_chan2_regs acc_chan2_props #(.SAMPLE_W(SAMPLE_W)) u_props (
  .I_MCLK(I_MCLK), .I_RST(I_RST), .I_CE(I_CE), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .I_PSTRB(I_PSTRB), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .I_GLOBAL_HIGHPASS_SETTING(I_GLOBAL_HIGHPASS_SETTING),
  .O_CHAN_TWO_DELAY_CYCLES(O_CHAN_TWO_DELAY_CYCLES),
  .O_HIGHPASS_ENABLE(O_HIGHPASS_ENABLE), .O_INPUT_ROUTE(O_INPUT_ROUTE),
  .I_SAMPLE_DATA(I_SAMPLE_DATA), .I_SAMPLE_VALID(I_SAMPLE_VALID),
  .O_RESULT_DATA(O_RESULT_DATA), .O_RESULT_VALID(O_RESULT_VALID));
